// File: design/sle_pkg.sv
package sle_pkg;

  // Clock and time base
  localparam int CLK_PERIOD_NS  = 10;
  localparam int NS_PER_MS      = 1000000;
  localparam int CYC_PER_MS     = NS_PER_MS / CLK_PERIOD_NS;
  localparam int BLINK1_HALF_MS = 500;
  localparam int BLINK2_HALF_MS = 250;
  localparam int FLICK_HALF_MS  = 50;
  localparam int FB_HOLD_MS     = 5000;

  // Register map (byte addresses)
  localparam int          APB_AW          = 8;
  localparam logic [7:0]  ADDR_ANALOG_EN  = 8'h00;
  localparam logic [7:0]  ADDR_UPPER_SP   = 8'h04;
  localparam logic [7:0]  ADDR_LOWER_SP   = 8'h08;
  localparam logic [7:0]  ADDR_LED_STAT   = 8'h0c;
  localparam logic [7:0]  ADDR_CHAN_STAT  = 8'h10;
  localparam logic [7:0]  ADDR_ETH_STAT   = 8'h14;
  localparam int          ETH_DPX_LSB     = 16;
  localparam logic [31:0] RST_ANALOG_EN   = 32'h0;
  localparam logic [31:0] RST_UPPER_SP    = 32'h0;
  localparam logic [31:0] RST_LOWER_SP    = 32'h0;

  // Blink generator phases
  localparam int BLK_ONE  = 0;
  localparam int BLK_TWO  = 1;
  localparam int BLK_FLK  = 2;
  localparam int BLK_NUM  = 3;
  localparam int NPORT    = 3;

  typedef enum logic [1:0] {
    SLE_CPU_OTHER,
    SLE_CPU_STOP,
    SLE_CPU_RUN,
    SLE_CPU_OPERATE
  } sle_cpu_t;

  // Processor and maintenance status
  typedef struct packed {
    sle_cpu_t cpu_state;
    logic     force_prepared;
    logic     force_active;
    logic     pt_write_conn;
    logic     single_step;
    logic     cfg_download;
    logic     reload_active;
    logic     cfg_exchange;
  } sle_maint_t;

  // Terminal, up, down and diagnostic port status
  typedef struct packed {
    logic             pt_connected;
    logic             pt_traffic;
    logic             pt_speed100;
    logic             up_conn;
    logic             down_conn;
    logic             diag_conn;
    logic [NPORT-1:0] full_duplex;
    logic [NPORT-1:0] collision;
  } sle_port_t;

  // Fixed LED set, one bit per lamp
  typedef struct packed {
    logic             force_led;
    logic             test_led;
    logic             load_led;
    logic             field_led;
    logic [1:0]       fb_led;
    logic             fb_fault_led;
    logic             pt_led;
    logic             pt_speed_led;
    logic             up_led;
    logic             down_led;
    logic             diag_led;
    logic [NPORT-1:0] port_dpx_led;
  } sle_led_t;

endpackage

// File: design/sle_top.sv
// How it works
// - Forcing prepared and CPU stop/run/operate: on
// - Forcing active in run/operate blinks; else dark
// - Test: write connection on, single-step blinks
// - Load lit during download in stop
// - Load blinks on reload or exchange
// - Channel: energized on, faulty blinks two
// - Field lit during boot LED test
// - Field blinks on any channel field fault
// - One channel LED per channel, parameter
// - Analog channel on above upper point
// - Analog channel off below lower point
// - Between points analog LED holds state
// - Field also shows transmitter supply fault
// - Fieldbus LEDs lit while bus operating
// - Fieldbus fault blinks at least five seconds
// - Ethernet link on, flickers with traffic
// - IP conflict blinks every Ethernet LED
// - Duplex on full, flicker collision, dark half
// - Terminal LED flickers traffic, conflict blinks
// - Terminal speed LED lit at 100 Mbit/s
// - Up and down LEDs lit when connected
// - Diagnostic LED lit when device connected
module sle_top
  import sle_pkg::*;
#(
  parameter int NCH          = 8,
  parameter int VW           = 16,
  parameter int NETH         = 4,
  parameter bit XMTR_SUPPORT = 1'b1,
  parameter int B1_HALF_CYC  = BLINK1_HALF_MS * CYC_PER_MS,
  parameter int B2_HALF_CYC  = BLINK2_HALF_MS * CYC_PER_MS,
  parameter int FLK_HALF_CYC = FLICK_HALF_MS * CYC_PER_MS,
  parameter int FB_HOLD_CYC  = FB_HOLD_MS * CYC_PER_MS
) (
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [APB_AW-1:0]       paddr,
  input  wire logic [31:0]             pwdata,
  output logic                         pready_ff,
  output logic [31:0]                  prdata_ff,
  output logic                         pslverr_ff,
  input  wire sle_maint_t              maint,
  input  wire logic [NCH-1:0]          ch_energized,
  input  wire logic [NCH-1:0]          ch_fault,
  input  wire logic [NCH-1:0]          ch_field_fault,
  input  wire logic [NCH-1:0][VW-1:0]  ch_value,
  input  wire logic                    boot_led_test,
  input  wire logic                    xmtr_supply_fault,
  input  wire logic [1:0]              fb_operating,
  input  wire logic                    fb_fault_evt,
  input  wire logic [NETH-1:0]         eth_link,
  input  wire logic [NETH-1:0]         eth_traffic,
  input  wire logic [NETH-1:0]         eth_full_duplex,
  input  wire logic [NETH-1:0]         eth_collision,
  input  wire logic                    ip_conflict,
  input  wire sle_port_t               port,
  output sle_led_t                     led_ff,
  output logic [NCH-1:0]               chan_led_ff,
  output logic [NETH-1:0]              eth_link_led_ff,
  output logic [NETH-1:0]              eth_dpx_led_ff
);

  localparam int HALF [BLK_NUM] = '{B1_HALF_CYC, B2_HALF_CYC, FLK_HALF_CYC};

  logic [31:0]     cnt_ff [BLK_NUM];
  logic [BLK_NUM-1:0] phase_ff;
  logic [NCH-1:0]  analog_en_ff;
  logic [VW-1:0]   upper_sp_ff;
  logic [VW-1:0]   lower_sp_ff;
  logic [NCH-1:0]  chan_an_ff;
  logic [31:0]     fb_hold_ff;
  sle_led_t        nxt_led;
  logic [NCH-1:0]  nxt_chan_led;
  logic [NETH-1:0] nxt_eth_link;
  logic [NETH-1:0] nxt_eth_dpx;

  // Blink generator: one toggling phase per pattern
  genvar g;
  generate
    for (g = 0; g < BLK_NUM; g++) begin : gen_blink
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          cnt_ff[g]   <= 32'h0;
          phase_ff[g] <= 1'b0;
        end else if (cnt_ff[g] == 32'(HALF[g] - 1)) begin
          cnt_ff[g]   <= 32'h0;
          phase_ff[g] <= ~phase_ff[g];
        end else begin
          cnt_ff[g]   <= cnt_ff[g] + 32'h1;
        end
      end
    end
  endgenerate

  wire blink1 = phase_ff[BLK_ONE];
  wire blink2 = phase_ff[BLK_TWO];
  wire flick  = phase_ff[BLK_FLK];

  // APB decode
  wire setup   = psel & ~penable;
  wire wr_done = psel & penable & pready_ff & pwrite;
  wire hit_an  = paddr == ADDR_ANALOG_EN;
  wire hit_up  = paddr == ADDR_UPPER_SP;
  wire hit_lo  = paddr == ADDR_LOWER_SP;
  wire hit_led = paddr == ADDR_LED_STAT;
  wire hit_ch  = paddr == ADDR_CHAN_STAT;
  wire hit_eth = paddr == ADDR_ETH_STAT;
  wire mapped  = hit_an | hit_up | hit_lo | hit_led | hit_ch | hit_eth;

  logic [31:0] eth_word;
  logic [31:0] rd_mux;
  assign eth_word = 32'(eth_link_led_ff)
                  | (32'(eth_dpx_led_ff) << ETH_DPX_LSB);
  assign rd_mux = hit_an  ? 32'(analog_en_ff) :
                  hit_up  ? 32'(upper_sp_ff)  :
                  hit_lo  ? 32'(lower_sp_ff)  :
                  hit_led ? 32'(led_ff)       :
                  hit_ch  ? 32'(chan_led_ff)  :
                  hit_eth ? eth_word          : 32'h0;

  // Bus answer: ready in the first access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff  <= 1'b0;
      prdata_ff  <= 32'h0;
      pslverr_ff <= 1'b0;
    end else begin
      pready_ff  <= setup;
      prdata_ff  <= setup ? rd_mux : 32'h0;
      pslverr_ff <= setup & ~mapped;
    end
  end

  // Configuration registers written by software
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      analog_en_ff <= NCH'(RST_ANALOG_EN);
      upper_sp_ff  <= VW'(RST_UPPER_SP);
      lower_sp_ff  <= VW'(RST_LOWER_SP);
    end else if (wr_done) begin
      if (hit_an) analog_en_ff <= pwdata[NCH-1:0];
      if (hit_up) upper_sp_ff  <= pwdata[VW-1:0];
      if (hit_lo) lower_sp_ff  <= pwdata[VW-1:0];
    end
  end

  // Analog hysteresis per channel
  genvar c;
  generate
    for (c = 0; c < NCH; c++) begin : gen_chan
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          chan_an_ff[c] <= 1'b0;
        end else if (ch_value[c] > upper_sp_ff) begin
          chan_an_ff[c] <= 1'b1;
        end else if (ch_value[c] < lower_sp_ff) begin
          chan_an_ff[c] <= 1'b0;
        end
      end
      // Fault blink over lit over dark
      assign nxt_chan_led[c] = ch_fault[c] ? blink2 :
        (analog_en_ff[c] ? chan_an_ff[c] : ch_energized[c]);
    end
  endgenerate

  // Fieldbus fault stretch
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fb_hold_ff <= 32'h0;
    end else if (fb_fault_evt) begin
      fb_hold_ff <= 32'(FB_HOLD_CYC);
    end else if (fb_hold_ff != 32'h0) begin
      fb_hold_ff <= fb_hold_ff - 32'h1;
    end
  end

  // Maintenance conditions
  wire cpu_run  = maint.cpu_state == SLE_CPU_RUN
               || maint.cpu_state == SLE_CPU_OPERATE;
  wire cpu_stop = maint.cpu_state == SLE_CPU_STOP;
  wire frc_blk  = maint.force_active & cpu_run;
  wire frc_on   = maint.force_prepared & (cpu_run | cpu_stop);
  wire load_blk = maint.reload_active | maint.cfg_exchange;
  wire load_on  = maint.cfg_download & cpu_stop;
  wire fld_blk  = (|ch_field_fault)
               | (XMTR_SUPPORT & xmtr_supply_fault);

  // Fixed LED next state, blink first then steady
  always_comb begin
    nxt_led = '0;
    nxt_led.force_led = frc_blk ? blink1 : frc_on;
    nxt_led.test_led  = maint.single_step ? blink1
                      : maint.pt_write_conn;
    nxt_led.load_led  = load_blk ? blink1 : load_on;
    nxt_led.field_led = fld_blk ? blink1
                      : boot_led_test;
    nxt_led.fb_led       = fb_operating;
    nxt_led.fb_fault_led = (fb_hold_ff != 32'h0) & blink1;
    nxt_led.pt_led = ip_conflict ? blink1
                   : port.pt_connected & port.pt_traffic & flick;
    nxt_led.pt_speed_led = ip_conflict ? blink1
                         : port.pt_connected & port.pt_speed100;
    nxt_led.up_led   = port.up_conn;
    nxt_led.down_led = port.down_conn;
    nxt_led.diag_led = port.diag_conn;
    for (int p = 0; p < NPORT; p++) begin
      nxt_led.port_dpx_led[p] = port.collision[p] ? flick
                              : port.full_duplex[p];
    end
  end

  // Ethernet LEDs: conflict, then activity, then steady
  assign nxt_eth_link = ip_conflict ? {NETH{blink1}}
    : (eth_link & ~eth_traffic) | (eth_link & eth_traffic
       & {NETH{flick}});
  assign nxt_eth_dpx = ip_conflict ? {NETH{blink1}}
    : (eth_collision & {NETH{flick}})
    | (~eth_collision & eth_full_duplex);

  // LED output registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      led_ff          <= '0;
      chan_led_ff     <= '0;
      eth_link_led_ff <= '0;
      eth_dpx_led_ff  <= '0;
    end else begin
      led_ff          <= nxt_led;
      chan_led_ff     <= nxt_chan_led;
      eth_link_led_ff <= nxt_eth_link;
      eth_dpx_led_ff  <= nxt_eth_dpx;
    end
  end

  // Forcing active shows pattern one
  force_blink_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (maint.force_active && cpu_run)
      |=> led_ff.force_led == $past(blink1))
    else $error("force LED not blinking");

  // Forcing prepared alone lights steadily
  force_on_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (maint.force_prepared && !maint.force_active && cpu_stop)
      |=> led_ff.force_led)
    else $error("force LED not lit");

  // Test LED stays dark without write connection or single-step
  test_led_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (!maint.single_step && !maint.pt_write_conn)
      |=> !led_ff.test_led)
    else $error("test LED lit without cause");

  // Download in stop lights the load LED
  load_on_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (load_on && !load_blk) |=> led_ff.load_led)
    else $error("load LED not lit");

  // Faulty channel shows pattern two
  chan_fault_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    ch_fault[0] |=> chan_led_ff[0] == $past(blink2))
    else $error("channel fault blink wrong");

  // Between switch points the analog state holds
  hyst_hold_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (ch_value[0] <= upper_sp_ff && ch_value[0] >= lower_sp_ff)
      |=> $stable(chan_an_ff[0]))
    else $error("hysteresis state moved");

  // Fault event keeps the fieldbus fault stretch running
  fb_hold_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    fb_fault_evt |=> (fb_hold_ff != 32'h0) [*8])
    else $error("fieldbus fault stretch too short");

  // Field fault blinks the field LED
  field_blink_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (|ch_field_fault) |=> led_ff.field_led == $past(blink1))
    else $error("field LED not blinking");

  // Address conflict blinks all Ethernet LEDs together
  ip_conflict_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    ip_conflict |=> (eth_link_led_ff == {NETH{$past(blink1)}})
      && (eth_dpx_led_ff == {NETH{$past(blink1)}}))
    else $error("Ethernet LEDs not blinking on conflict");

  // Up port LED tracks physical connection
  up_port_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    1'b1 |=> led_ff.up_led == $past(port.up_conn))
    else $error("up port LED wrong");

  // Reload or exchange blinks the load LED
  load_blink_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    load_blk |=> led_ff.load_led == $past(blink1))
    else $error("load LED not blinking");

  // Boot lamp test lights the field LED
  boot_test_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (boot_led_test && !fld_blk) |=> led_ff.field_led)
    else $error("field LED dark during lamp test");

  // Value above the upper point sets the analog state
  hyst_on_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (ch_value[0] > upper_sp_ff) |=> chan_an_ff[0])
    else $error("analog state not set");

  // Value below the lower point clears the analog state
  hyst_off_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (ch_value[0] < lower_sp_ff && ch_value[0] <= upper_sp_ff)
      |=> !chan_an_ff[0])
    else $error("analog state not cleared");

  // Fieldbus LEDs follow the operating flags
  fb_lamp_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    1'b1 |=> led_ff.fb_led == $past(fb_operating))
    else $error("fieldbus LED wrong");

  // Quiet link with a partner lights steadily
  eth_link_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (eth_link[0] && !eth_traffic[0] && !ip_conflict)
      |=> eth_link_led_ff[0])
    else $error("Ethernet link LED not lit");

  // Diagnostic LED tracks physical connection
  diag_port_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    1'b1 |=> led_ff.diag_led == $past(port.diag_conn))
    else $error("diagnostic LED wrong");

endmodule

// File: verif/sle_panel.sv
// Front panel: grades each lamp over a fixed window
module sle_panel #(
  parameter int W   = 23,
  parameter int WIN = 32
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [W-1:0] lamp,
  output logic [W-1:0][2:0] code_ff
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0]        cyc_ff;
  logic [W-1:0]      prev_ff;
  logic [W-1:0][4:0] edg_ff;

  // Grades: 0 dark, 1 lit, 2 slow, 3 fast, 4 flicker
  function automatic logic [2:0] grade(input logic l,
                                       input logic [4:0] e);
    if (e == 5'h0) return {2'h0, l};
    if (e < 5'h6) return 3'h2;
    if (e < 5'hb) return 3'h3;
    return 3'h4;
  endfunction

  // Counts toggles per lamp, grades them at window end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cyc_ff  <= 8'h0;
      prev_ff <= '0;
      edg_ff  <= '0;
      code_ff <= '0;
    end else begin
      prev_ff <= lamp;
      cyc_ff  <= (cyc_ff == 8'(WIN - 1)) ? 8'h0 : cyc_ff + 8'h1;
      for (int i = 0; i < W; i++) begin
        if (cyc_ff == 8'(WIN - 1)) begin
          code_ff[i] <= grade(lamp[i], edg_ff[i]);
          edg_ff[i]  <= 5'h0;
        end else if (lamp[i] != prev_ff[i]) begin
          edg_ff[i] <= edg_ff[i] + 5'h1;
        end
      end
    end
  end
endmodule

// File: verif/status_led_encoder_bench.sv
module status_led_encoder_bench
  import sle_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [2:0] OFF = 3'h0, ON = 3'h1, B1 = 3'h2;
  localparam logic [2:0] B2 = 3'h3, FL = 3'h4;
  logic             pclk = 1'h0, presetn = 1'h0;
  logic             psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [7:0]       paddr = 8'h0;
  logic [31:0]      pwdata = 32'h0, prdata_ff;
  logic             pready_ff, pslverr_ff;
  sle_maint_t       maint = '0;
  sle_port_t        port = '0;
  sle_led_t         led_ff;
  logic [3:0]       ch_energized = '0, ch_fault = '0, chan_led_ff;
  logic [3:0]       ch_field_fault = '0;
  logic [3:0][7:0]  ch_value = '0;
  logic             boot_led_test = 1'h0, xmtr_supply_fault = 1'h0;
  logic             fb_fault_evt = 1'h0, ip_conflict = 1'h0;
  logic [1:0]       fb_operating = '0, eth_link = '0, eth_traffic = '0;
  logic [1:0]       eth_full_duplex = '0, eth_collision = '0;
  logic [1:0]       eth_link_led_ff, eth_dpx_led_ff;
  logic [22:0][2:0] code_ff, exp_c = '0;
  int               mismatches, samples_checked, cycles;

  sle_top #(
    .NCH(4), .VW(8), .NETH(2), .B1_HALF_CYC(8), .B2_HALF_CYC(4),
    .FLK_HALF_CYC(2), .FB_HOLD_CYC(100)
  ) DUT (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pready_ff, .prdata_ff, .pslverr_ff, .maint, .ch_energized,
    .ch_fault, .ch_field_fault, .ch_value, .boot_led_test,
    .xmtr_supply_fault, .fb_operating, .fb_fault_evt, .eth_link,
    .eth_traffic, .eth_full_duplex, .eth_collision, .ip_conflict,
    .port, .led_ff, .chan_led_ff, .eth_link_led_ff, .eth_dpx_led_ff
  );

  sle_panel PANEL (
    .pclk,
    .presetn,
    .lamp    ({led_ff, chan_led_ff, eth_link_led_ff, eth_dpx_led_ff}),
    .code_ff
  );

  always #5 pclk = ~pclk;

  // Cuts a hang short
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      wrap_up();
    end
  end

  // One APB transfer, held until pready is seen
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [32:0] r);
    psel    <= 1'h1;
    penable <= 1'h0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do begin
      @(posedge pclk);
    end while (pready_ff !== 1'h1);
    r = {pslverr_ff, prdata_ff};
    psel    <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [32:0] r;
    xfer(1'h1, a, d, r);
  endtask

  // Reads a register and compares error flag and data
  task automatic rd(input logic [7:0] a, input logic [32:0] e);
    logic [32:0] r;
    xfer(1'h0, a, 32'h0, r);
    samples_checked++;
    if (r !== e) begin
      mismatches++;
      $display("unexpected reg %h: exp %h seen %h", a, e, r);
    end
  endtask

  // Lets the lamps settle, then compares every grade
  task automatic chk_lamps();
    repeat (70) @(posedge pclk);
    for (int i = 0; i < 23; i++) begin
      samples_checked++;
      if (code_ff[i] !== exp_c[i]) begin
        mismatches++;
        $display("unexpected lamp %0d: exp %0d seen %0d", i, exp_c[i],
                 code_ff[i]);
      end
    end
  endtask

  task automatic wrap_up();
    $display("checked %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    rd(ADDR_UPPER_SP, 33'h0);
    rd(8'h20, 33'h1_0000_0000);
    wr(ADDR_UPPER_SP, 32'h64);
    wr(ADDR_LOWER_SP, 32'h32);
    wr(ADDR_ANALOG_EN, 32'h1);
    rd(ADDR_LOWER_SP, 33'h32);
    // Steady states; terminal linked with traffic at 100 Mbit/s
    maint <= {SLE_CPU_RUN, 7'h50};
    ch_energized <= 4'h2;
    ch_fault <= 4'h4;
    ch_value[0] <= 8'h78;
    boot_led_test <= 1'h1;
    fb_operating <= 2'h1;
    eth_link <= 2'h3;
    eth_traffic <= 2'h2;
    eth_full_duplex <= 2'h1;
    eth_collision <= 2'h2;
    port <= 12'hf4c;
    exp_c[22:12] = {ON, ON, OFF, ON, OFF, ON, OFF, FL, ON, ON, OFF};
    exp_c[11:0] = {ON, FL, OFF, ON, OFF, B2, ON, ON, FL, ON, FL, ON};
    chk_lamps();
    // Blinking conditions over steady ones
    maint <= {SLE_CPU_RUN, 7'h78};
    ch_fault <= 4'h6;
    ch_value[0] <= 8'h46;
    ch_field_fault <= 4'h8;
    exp_c[22:21] = {B1, B1};
    exp_c[19] = B1;
    exp_c[5] = B2;
    chk_lamps();
    // Download in stop, supply fault, down port, 10 Mbit/s
    maint <= {SLE_CPU_STOP, 7'h04};
    ch_value[0] <= 8'h1e;
    ch_field_fault <= 4'h0;
    boot_led_test <= 1'h0;
    xmtr_supply_fault <= 1'h1;
    port <= 12'hdcc;
    exp_c[22:19] = {OFF, OFF, ON, B1};
    exp_c[14] = OFF;
    exp_c[12] = ON;
    exp_c[4] = OFF;
    chk_lamps();
    // Reload, value at the upper point, one fieldbus fault event
    maint <= {SLE_CPU_STOP, 7'h02};
    ch_value[0] <= 8'h64;
    xmtr_supply_fault <= 1'h0;
    fb_fault_evt <= 1'h1;
    @(posedge pclk);
    fb_fault_evt <= 1'h0;
    exp_c[20:19] = {B1, OFF};
    exp_c[16] = B1;
    chk_lamps();
    // Fault stretch expired; address conflict
    repeat (40) @(posedge pclk);
    maint <= {SLE_CPU_STOP, 7'h01};
    ip_conflict <= 1'h1;
    exp_c[16:14] = {OFF, B1, B1};
    exp_c[3:0] = {B1, B1, B1, B1};
    chk_lamps();
    // Conflict gone, nothing loading, value just above upper point
    maint <= {SLE_CPU_STOP, 7'h00};
    ip_conflict <= 1'h0;
    ch_value[0] <= 8'h65;
    exp_c[20] = OFF;
    exp_c[15:14] = {FL, OFF};
    exp_c[4:0] = {ON, FL, ON, FL, ON};
    chk_lamps();
    // Mid-run reset clears settings; channel, bus and Ethernet inputs move
    presetn <= 1'h0;
    repeat (3) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    rd(ADDR_UPPER_SP, 33'h0);
    rd(ADDR_ANALOG_EN, 33'h0);
    ch_energized <= 4'h9;
    fb_operating <= 2'h2;
    eth_link <= 2'h1;
    eth_traffic <= 2'h0;
    eth_full_duplex <= 2'h2;
    eth_collision <= 2'h0;
    exp_c[18:17] = {ON, OFF};
    exp_c[7] = ON;
    exp_c[3:0] = {OFF, ON, ON, OFF};
    chk_lamps();
    wrap_up();
  end
endmodule
